// File: design/cdr_defs.svh
`ifndef CDR_DEFS_SVH
`define CDR_DEFS_SVH

// register byte offsets on the bus, one aligned word each
`define CDR_OFF_IPTR 8'h00
`define CDR_OFF_ACC 8'h04
`define CDR_OFF_TACC 8'h08
`define CDR_OFF_IDX 8'h0c
`define CDR_OFF_EXT 8'h10
`define CDR_OFF_STK 8'h14
`define CDR_OFF_PSW 8'h18

// reset values
`define CDR_IPTR_RST 16'hfffd
`define CDR_DATA_RST 16'h0000

// condition flag positions inside the status word
`define CDR_F_C 0
`define CDR_F_V 1
`define CDR_F_Z 2
`define CDR_F_N 3
`define CDR_F_IL0 4
`define CDR_F_IL1 5
`define CDR_F_I 6
`define CDR_F_H 7

// bank pointer field inside the status word
`define CDR_BANK_LSB 11
`define CDR_BANK_MSB 15

// fixed upper address byte of the banked register area
`define CDR_GPR_HI 8'h01

// mask value at which nothing is serviced
`define CDR_IL_NONE 2'h2

// byte and nibble boundaries
`define CDR_B3 3
`define CDR_B7 7
`define CDR_B15 15

`endif

// File: design/cdr_pkg.sv
package cdr_pkg;

  // operations of the arithmetic datapath
  typedef enum logic [3:0] {
    CDR_OP_ADD,
    CDR_OP_ADDC,
    CDR_OP_SUB,
    CDR_OP_SUBC,
    CDR_OP_CMP,
    CDR_OP_AND,
    CDR_OP_OR,
    CDR_OP_XOR,
    CDR_OP_SHL,
    CDR_OP_SHR
  } cdr_op_t;

  // register select for core-side loads
  typedef enum logic [2:0] {
    CDR_SEL_IPTR,
    CDR_SEL_ACC,
    CDR_SEL_TACC,
    CDR_SEL_IDX,
    CDR_SEL_EXT,
    CDR_SEL_STK,
    CDR_SEL_PSW
  } cdr_sel_t;

  // whole state of the register block
  typedef struct packed {
    logic [15:0] iptr;
    logic [15:0] acc;
    logic [15:0] tacc;
    logic [15:0] idx;
    logic [15:0] ext;
    logic [15:0] stk;
    logic [15:0] psw;
    logic [31:0] prdata;
    logic slverr;
    logic irq_ack;
    logic [15:0] alu_res;
  } cdr_state_t;

endpackage : cdr_pkg

// File: design/cdr_regs.sv
// Overview of operation
// - 16-bit instruction pointer, resets to fffd
// - accumulators 16 bits, byte ops use low
// - secondary accumulator is second ALU operand
// - extra, index and stack pointers 16 bits
// - status word: bank pointer high, flags low
// - bank address: 0000_0001, pointer, opcode bits
// - 32 banks of eight byte registers
// - general registers live in data memory
// - half-carry from bit 3 into 4
// - interrupt enable gates acceptance, reset clears
// - service only above current mask level
// - mask 00/01/10 are levels 1/2/3
// - negative flag follows result msb
// - zero flag set on zero result
// - overflow flag on two's complement overflow
// - carry flag from carry/borrow out of msb
// - shifts load carry with shifted-out bit
`timescale 1ns/1ps
`default_nettype none
// shared offsets, field positions and reset values
`include "cdr_defs.svh"

module cdr_regs (
  input wire logic pclk, // core clock, 125 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic core_ld, // core register load strobe
  input wire logic [2:0] core_sel, // register to load
  input wire logic [15:0] core_data, // load value
  input wire logic iptr_inc, // step instruction pointer
  input wire logic alu_go, // run one datapath operation
  input wire logic [3:0] alu_op, // operation code
  input wire logic alu_wide, // 1: 16-bit operation
  input wire logic [2:0] gpr_code, // low opcode bits
  output logic [15:0] gpr_addr, // banked register address
  input wire logic irq_req, // pending interrupt request
  input wire logic [1:0] irq_level, // level of that request
  output logic irq_ack, // request accepted, one cycle after each qualifying cycle
  output logic [15:0] instruction_pointer, // next instruction
  output logic [15:0] accumulator, // main accumulator
  output logic [15:0] secondary_accumulator, // second operand
  output logic [15:0] index_pointer, // index register
  output logic [15:0] extra_address_pointer, // extra pointer
  output logic [15:0] stack_top_pointer, // stack pointer
  output logic [15:0] processor_status_word, // bank ptr + flags
  output logic [15:0] alu_result // last datapath result
);

  cdr_pkg::cdr_state_t st_r;
  cdr_pkg::cdr_state_t st_nxt;

  // map the 2-bit level code to priority, 1 highest
  function automatic logic [1:0] cdr_lvl(input logic [1:0] code);
    logic [1:0] l;
    case (code)
      2'h0: l = 2'h1;
      2'h1: l = 2'h2;
      2'h2: l = 2'h3;
      default: l = 2'h2;
    endcase
    return l;
  endfunction : cdr_lvl

  // read mux over the register words
  function automatic logic [31:0] cdr_rd(input cdr_pkg::cdr_state_t s,
                                         input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `CDR_OFF_IPTR: d = {16'h0000, s.iptr};
      `CDR_OFF_ACC: d = {16'h0000, s.acc};
      `CDR_OFF_TACC: d = {16'h0000, s.tacc};
      `CDR_OFF_IDX: d = {16'h0000, s.idx};
      `CDR_OFF_EXT: d = {16'h0000, s.ext};
      `CDR_OFF_STK: d = {16'h0000, s.stk};
      `CDR_OFF_PSW: d = {16'h0000, s.psw};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : cdr_rd

  // address decode for the error answer
  function automatic logic cdr_hit(input logic [7:0] a);
    logic h;
    case (a)
      `CDR_OFF_IPTR, `CDR_OFF_ACC, `CDR_OFF_TACC, `CDR_OFF_IDX,
      `CDR_OFF_EXT, `CDR_OFF_STK, `CDR_OFF_PSW: h = 1'b1;
      default: h = 1'b0;
    endcase
    return h;
  endfunction : cdr_hit

  // store a 16-bit word into one register of the state
  function automatic cdr_pkg::cdr_state_t cdr_put(
      input cdr_pkg::cdr_state_t s, input logic [2:0] sel,
      input logic [15:0] d);
    cdr_pkg::cdr_state_t o;
    o = s;
    case (sel)
      3'h0: o.iptr = d;
      3'h1: o.acc = d;
      3'h2: o.tacc = d;
      3'h3: o.idx = d;
      3'h4: o.ext = d;
      3'h5: o.stk = d;
      3'h6: o.psw = d;
      default: o = s;
    endcase
    return o;
  endfunction : cdr_put

  // state update: bus slave, core loads, datapath, interrupts
  always_comb
  begin
    logic [16:0] sum;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] res;
    logic [4:0] nib;
    logic cin;
    logic msb_a;
    logic msb_b;
    logic msb_r;
    logic sub;
    logic wr_res;
    logic arith;
    logic cout;
    logic [2:0] bsel;
    cdr_pkg::cdr_op_t op;
    sum = 17'h0_0000;
    opa = 16'h0000;
    opb = 16'h0000;
    res = 16'h0000;
    nib = 5'h00;
    cin = 1'b0;
    msb_a = 1'b0;
    msb_b = 1'b0;
    msb_r = 1'b0;
    sub = 1'b0;
    wr_res = 1'b0;
    arith = 1'b0;
    cout = 1'b0;
    bsel = 3'h0;
    op = cdr_pkg::cdr_op_t'(alu_op);
    st_nxt = st_r;
    st_nxt.irq_ack = 1'b0;

    // apb setup phase latches read data and error answer
    if (psel && !penable)
    begin
      st_nxt.prdata = cdr_rd(st_r, paddr);
      st_nxt.slverr = !cdr_hit(paddr);
    end

    // apb write takes effect at the end of the access phase
    if (psel && penable && pwrite && cdr_hit(paddr))
    begin
      bsel = 3'(paddr[7:2]);
      st_nxt = cdr_put(st_nxt, bsel, pwdata[15:0]);
    end

    // pointer steps to the next instruction
    if (iptr_inc)
      st_nxt.iptr = st_r.iptr + 16'h0001;

    // core loads of pointers and other registers
    if (core_ld)
      st_nxt = cdr_put(st_nxt, core_sel, core_data);

    opa = alu_wide ? st_r.acc : {8'h00, st_r.acc[7:0]};
    opb = alu_wide ? st_r.tacc : {8'h00, st_r.tacc[7:0]};
    cin = st_r.psw[`CDR_F_C];
    sub = (op == cdr_pkg::CDR_OP_SUB) || (op == cdr_pkg::CDR_OP_SUBC)
          || (op == cdr_pkg::CDR_OP_CMP);
    case (op)
      cdr_pkg::CDR_OP_ADD:
      begin
        sum = {1'b0, opa} + {1'b0, opb};
        arith = 1'b1;
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_ADDC:
      begin
        sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
        arith = 1'b1;
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_SUB, cdr_pkg::CDR_OP_CMP:
      begin
        sum = {1'b0, opa} - {1'b0, opb};
        arith = 1'b1;
        wr_res = (op == cdr_pkg::CDR_OP_SUB);
      end
      cdr_pkg::CDR_OP_SUBC:
      begin
        sum = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin};
        arith = 1'b1;
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_AND:
      begin
        sum = {1'b0, opa & opb};
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_OR:
      begin
        sum = {1'b0, opa | opb};
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_XOR:
      begin
        sum = {1'b0, opa ^ opb};
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_SHL:
      begin
        // bit leaving the top lands in carry
        sum = {1'b0, opa[14:0], cin};
        cout = alu_wide ? opa[`CDR_B15] : opa[`CDR_B7];
        wr_res = 1'b1;
      end
      cdr_pkg::CDR_OP_SHR:
      begin
        // bit leaving the bottom lands in carry
        sum = alu_wide ? {1'b0, cin, opa[15:1]}
                       : {9'h000, cin, opa[7:1]};
        cout = opa[0];
        wr_res = 1'b1;
      end
      default:
      begin
        sum = 17'h0_0000;
        wr_res = 1'b0;
      end
    endcase

    // byte operations keep only the low byte
    res = alu_wide ? sum[15:0] : {8'h00, sum[7:0]};
    msb_a = alu_wide ? opa[`CDR_B15] : opa[`CDR_B7];
    msb_b = (alu_wide ? opb[`CDR_B15] : opb[`CDR_B7]) ^ sub;
    msb_r = alu_wide ? res[`CDR_B15] : res[`CDR_B7];
    // nibble carry, same add/subtract as the main sum
    nib = sub ? ({1'b0, opa[3:0]} - {1'b0, opb[3:0]}
                 - {4'h0, cin & (op == cdr_pkg::CDR_OP_SUBC)})
              : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]}
                 + {4'h0, cin & (op == cdr_pkg::CDR_OP_ADDC)});

    // undefined op codes write neither result nor flags
    // a stray code from the decoder then cannot corrupt the flags
    if (alu_go && (arith || wr_res))
    begin
      st_nxt.alu_res = res;
      // upper accumulator byte untouched by byte ops
      if (wr_res)
        st_nxt.acc = alu_wide ? res : {st_r.acc[15:8], res[7:0]};
      st_nxt.psw[`CDR_F_N] = msb_r;
      st_nxt.psw[`CDR_F_Z] = (res == 16'h0000);
      if (arith)
      begin
        // carry or borrow out of the msb
        st_nxt.psw[`CDR_F_C] = alu_wide ? sum[16] : sum[8];
        // signed overflow: like signs, sign flipped
        st_nxt.psw[`CDR_F_V] = (msb_a == msb_b) && (msb_r != msb_a);
        // half carry across the bit 3 boundary
        st_nxt.psw[`CDR_F_H] = nib[4];
      end
      else if (op == cdr_pkg::CDR_OP_SHL || op == cdr_pkg::CDR_OP_SHR)
        st_nxt.psw[`CDR_F_C] = cout;
      // logic ops leave carry, overflow, half carry alone
    end

    // request must outrank the current mask
    // mask code 10 shuts everything out
    if (irq_req && st_r.psw[`CDR_F_I]
        && (st_r.psw[`CDR_F_IL1:`CDR_F_IL0] != `CDR_IL_NONE)
        && (cdr_lvl(irq_level)
            < cdr_lvl(st_r.psw[`CDR_F_IL1:`CDR_F_IL0])))
      st_nxt.irq_ack = 1'b1;
  end

  // single state register; only constants under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // pointer starts at the reset entry
      st_r.iptr <= `CDR_IPTR_RST;
      st_r.acc <= `CDR_DATA_RST;
      st_r.tacc <= `CDR_DATA_RST;
      st_r.idx <= `CDR_DATA_RST;
      st_r.ext <= `CDR_DATA_RST;
      st_r.stk <= `CDR_DATA_RST;
      st_r.psw <= `CDR_DATA_RST;
      st_r.prdata <= 32'h0000_0000;
      st_r.slverr <= 1'b0;
      st_r.irq_ack <= 1'b0;
      st_r.alu_res <= `CDR_DATA_RST;
    end
    else
      st_r <= st_nxt;
  end

  // apb answers with no wait states
  assign pready = 1'b1;
  assign prdata = st_r.prdata;
  assign pslverr = st_r.slverr && psel && penable;

  // bank pointer in the high byte, flags in the low
  // banked address: fixed high byte, pointer, opcode
  // five pointer bits choose one of 32 banks
  // the registers themselves sit in data memory
  assign gpr_addr = {`CDR_GPR_HI,
                     st_r.psw[`CDR_BANK_MSB:`CDR_BANK_LSB], gpr_code};

  // register contents straight from the flops
  assign irq_ack = st_r.irq_ack;
  assign instruction_pointer = st_r.iptr;
  assign accumulator = st_r.acc;
  assign secondary_accumulator = st_r.tacc;
  assign index_pointer = st_r.idx;
  assign extra_address_pointer = st_r.ext;
  assign stack_top_pointer = st_r.stk;
  assign processor_status_word = st_r.psw;
  assign alu_result = st_r.alu_res;

endmodule : cdr_regs

`default_nettype wire

// File: tb/cdr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cdr_regs_chk (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset
  input wire logic alu_go, // op strobe
  input wire logic [3:0] alu_op, // op code
  input wire logic alu_wide, // 16-bit op
  input wire logic [2:0] gpr_code, // opcode bits
  input wire logic [15:0] gpr_addr, // bank address
  input wire logic irq_req, // request
  input wire logic [1:0] irq_level, // request level
  input wire logic irq_ack, // accepted
  input wire logic [15:0] instruction_pointer, // ip
  input wire logic [15:0] accumulator, // acc
  input wire logic [15:0] processor_status_word // psw
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ops that write accumulator and flags; compare writes flags only
  sequence s_wr_op;
    alu_go && (alu_op inside {[0:3], [5:9]});
  endsequence
  sequence s_byte_op;
    s_wr_op ##0 !alu_wide;
  endsequence
  sequence s_logic_op;
    alu_go && (alu_op inside {[5:7]});
  endsequence
  sequence s_irq_on;
    irq_req && processor_status_word[6];
  endsequence
  // reset leaves the pointer at its start
  AST_IPTR_RST: assert property ($rose(presetn) |-> // start value
    instruction_pointer == 16'hfffd) else $error("ip reset value");
  AST_GPR: assert property (gpr_addr == {8'h01, // bank address
    processor_status_word[15:11], gpr_code}) else $error("bank addr");
  AST_IRQ_OFF: assert property (irq_req && !processor_status_word[6]
    |=> !irq_ack) else $error("ack while disabled");
  AST_IRQ_NONE: assert property (s_irq_on ##0 // lowest level
    processor_status_word[5:4] == 2'b10 |=> !irq_ack) else $error("mask 10");
  AST_IRQ_PRIO: assert property (s_irq_on ##0 // no higher level
    processor_status_word[5:4] == 2'b00 |=> !irq_ack) else $error("mask 00");
  AST_IRQ_OK: assert property (s_irq_on ##0 // higher level taken
    (processor_status_word[5:4] == 2'b01 && irq_level == 2'b00) |=> irq_ack)
    else $error("missing ack");
  AST_ZERO: assert property (s_wr_op |=> // zero result
    processor_status_word[2] == ($past(alu_wide) ? accumulator == 16'h0000
    : accumulator[7:0] == 8'h00)) else $error("zero flag");
  AST_NEG: assert property (s_wr_op |=> // result msb
    processor_status_word[3] == ($past(alu_wide) ? accumulator[15]
    : accumulator[7])) else $error("negative flag");
  AST_BYTE_KEEP: assert property (s_byte_op |=> // high byte kept
    $stable(accumulator[15:8])) else $error("high byte changed");
  AST_FLAG_KEEP: assert property (s_logic_op |=> // carry, overflow, half untouched
    $stable(processor_status_word[7]) && $stable(processor_status_word[1:0]))
    else $error("logic op changed flags");
endmodule : cdr_regs_chk

bind cdr_regs cdr_regs_chk u_chk (.pclk, .presetn, .alu_go, .alu_op,
  .alu_wide, .gpr_code, .gpr_addr, .irq_req, .irq_level, .irq_ack,
  .instruction_pointer, .accumulator, .processor_status_word);

`default_nettype wire

// File: tb/cdr_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module cdr_core_model (
  input wire logic pclk, // core clock
  output logic core_ld, // load strobe
  output logic [2:0] core_sel, // load target
  output logic [15:0] core_data, // load value
  output logic iptr_inc, // ip step
  output logic alu_go, // op strobe
  output logic [3:0] alu_op, // op code
  output logic alu_wide, // 16-bit op
  output logic [2:0] gpr_code, // opcode bits
  output logic irq_req, // request
  output logic [1:0] irq_level // request level
);
  // idle decoder at time zero
  initial
  begin
    {core_ld, core_sel, core_data, iptr_inc} = '0;
    {alu_go, alu_op, alu_wide, gpr_code, irq_req, irq_level} = '0;
  end
  // released strobes show inverted core_data and alu_op; core_sel and alu_wide keep their values
  task ld(input logic [2:0] s, input logic [15:0] d);
    @(posedge pclk);
    core_ld <= 1'b1;
    core_sel <= s;
    core_data <= d;
    @(posedge pclk);
    core_ld <= 1'b0;
    core_data <= ~d;
  endtask : ld
  task alu(input logic [3:0] op, input logic w);
    @(posedge pclk);
    alu_go <= 1'b1;
    alu_op <= op;
    alu_wide <= w;
    @(posedge pclk);
    alu_go <= 1'b0;
    alu_op <= ~op;
  endtask : alu
  task step();
    @(posedge pclk);
    iptr_inc <= 1'b1;
    @(posedge pclk);
    iptr_inc <= 1'b0;
  endtask : step
  task sig(input logic r, input logic [1:0] l, input logic [2:0] c);
    @(posedge pclk);
    irq_req <= r;
    irq_level <= l;
    gpr_code <= c;
  endtask : sig
endmodule : cdr_core_model

`default_nettype wire

// File: tb/cpu_dedicated_registers_ccr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_dedicated_registers_ccr_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] gpr_addr, core_data, rnd, av, tv;
  logic [15:0] tacc_o, idx_o, ext_o, stk_o, alu_res;
  logic [15:0] wv [6];
  logic [23:0] e;
  logic core_ld, iptr_inc, alu_go, alu_wide, irq_req;
  logic [2:0] core_sel, gpr_code;
  logic [3:0] alu_op;
  logic [1:0] irq_level;
  logic [32:0] exp_q[$], exq;
  string name_q[$], nmq;
  int fails, comparisons, i;
  // psw, request level, expected ack
  logic [18:0] irq_tab [7] = '{19'h00281, 19'h00282, 19'h00300,
    19'h00080, 19'h00381, 19'h00382, 19'h00200};

  cdr_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_ld, .core_sel, .core_data,
    .iptr_inc, .alu_go, .alu_op, .alu_wide, .gpr_code, .gpr_addr, .irq_req,
    .irq_level, .irq_ack, .instruction_pointer(), .accumulator(),
    .secondary_accumulator(tacc_o), .index_pointer(idx_o),
    .extra_address_pointer(ext_o), .stack_top_pointer(stk_o),
    .processor_status_word(), .alu_result(alu_res));
  cdr_core_model u_core (.pclk, .core_ld, .core_sel, .core_data, .iptr_inc,
    .alu_go, .alu_op, .alu_wide, .gpr_code, .irq_req, .irq_level);

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // byte add: {flags, acc}; high byte kept
  function automatic logic [23:0] add8(input logic [15:0] x, y);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x[7:0]} + {1'b0, y[7:0]};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    return {h[4], 3'h0, s[7], s[7:0] == 8'h00,
      (x[7] == y[7]) && (s[7] != x[7]), s[8], x[15:8], s[7:0]};
  endfunction : add8
  task check(input logic [32:0] seen, exp, input string nm);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task stop_test();
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // expectation is noted at setup, compared in access phase
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
    input logic [32:0] ex, input string nm);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    exp_q.push_back(ex);
    name_q.push_back(nm);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : apb
  task rd(input logic [7:0] ad, input logic [15:0] ex, input string nm);
    apb(1'b0, ad, 32'h0, {17'h0, ex}, nm);
  endtask : rd
  // one process pops and compares, so no race on the queue head
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      exq = exp_q.pop_front();
      nmq = name_q.pop_front();
      check(pwrite ? {pslverr, 32'h0} : {pslverr, prdata},
        pwrite ? {exq[32], 32'h0} : exq, nmq); // bus answer
    end
  // hang guard, far beyond the few hundred cycles used
  initial
  begin
    repeat (5000) @(posedge pclk);
    fails++;
    stop_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    rnd = 16'h0015;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 16'hfffd, "iptr"); // start value
    rd(8'h18, 16'h0000, "psw"); // enable cleared
    u_core.step();
    rd(8'h00, 16'hfffe, "iptr step"); // pointer counts
    apb(1'b1, 8'h1c, 32'hffffffff, {1'b1, 32'h0}, "unmapped wr");
    apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0}, "unmapped rd");
    for (i = 1; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      apb(1'b1, 8'(i * 4), {rnd, ~rnd}, 33'h0, "wr");
      rd(8'(i * 4), ~rnd, "reg"); // sixteen bits held
      wv[i] = ~rnd;
    end
    #1 check({17'h0, tacc_o}, {17'h0, wv[2]}, "tacc out");
    check({17'h0, idx_o}, {17'h0, wv[3]}, "idx out");
    check({17'h0, ext_o}, {17'h0, wv[4]}, "ext out");
    check({17'h0, stk_o}, {17'h0, wv[5]}, "stk out");
    for (i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      u_core.sig(1'b0, 2'b00, rnd[7:5]);
      u_core.ld(3'd6, {rnd[4:0], 11'h0});
      #1 check({17'h0, gpr_addr}, {25'h1, rnd[4:0], rnd[7:5]}, "gpr");
    end
    for (i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      av = (i == 0) ? 16'h127f : (i == 1) ? 16'h34ff : rnd;
      rnd = lfsr(rnd);
      tv = (i < 2) ? 16'h0001 : rnd;
      e = add8(av, tv);
      u_core.ld(3'd6, 16'h0000);
      u_core.ld(3'd1, av);
      u_core.ld(3'd2, tv);
      u_core.alu(cdr_pkg::CDR_OP_ADD, 1'b0);
      rd(8'h04, e[15:0], "acc"); // byte sum, high kept
      rd(8'h18, {8'h0, e[23:16]}, "flags"); // flag set
    end
    u_core.ld(3'd6, 16'h0081);
    u_core.ld(3'd1, 16'ha540);
    u_core.ld(3'd2, 16'h000f);
    u_core.alu(cdr_pkg::CDR_OP_SHL, 1'b0);
    rd(8'h04, 16'ha581, "shl acc"); // carry shifted in
    rd(8'h18, 16'h0088, "shl flags"); // carry from bit 7
    u_core.alu(cdr_pkg::CDR_OP_AND, 1'b0);
    rd(8'h18, 16'h0080, "and flags"); // carry and half kept
    u_core.alu(cdr_pkg::CDR_OP_SHR, 1'b0);
    rd(8'h04, 16'ha500, "shr acc"); // old carry in
    rd(8'h18, 16'h0085, "shr flags"); // bit 0 out
    u_core.ld(3'd1, 16'hffff);
    u_core.ld(3'd2, 16'h0001);
    u_core.alu(cdr_pkg::CDR_OP_ADD, 1'b1);
    rd(8'h18, 16'h0085, "wide flags"); // full width carry
    rd(8'h04, 16'h0000, "wide acc"); // upper byte written too
    u_core.ld(3'd6, 16'h0000);
    u_core.ld(3'd1, 16'h1200);
    u_core.alu(cdr_pkg::CDR_OP_SUB, 1'b0);
    rd(8'h04, 16'h12ff, "sub acc"); // low byte only
    rd(8'h18, 16'h0089, "sub flags"); // borrow out
    u_core.alu(cdr_pkg::CDR_OP_SUBC, 1'b0);
    rd(8'h04, 16'h12fd, "subc acc"); // borrow taken in
    rd(8'h18, 16'h0008, "subc flags"); // no borrow
    u_core.ld(3'd2, 16'h00fd);
    u_core.alu(cdr_pkg::CDR_OP_CMP, 1'b0);
    rd(8'h04, 16'h12fd, "cmp acc"); // compare keeps acc
    rd(8'h18, 16'h0004, "cmp flags"); // equal gives zero
    u_core.ld(3'd6, 16'h0001);
    u_core.alu(cdr_pkg::CDR_OP_ADDC, 1'b0);
    rd(8'h04, 16'h12fb, "addc acc"); // carry added in
    rd(8'h18, 16'h0089, "addc flags"); // carries out
    u_core.alu(cdr_pkg::CDR_OP_XOR, 1'b0);
    rd(8'h18, 16'h0081, "xor flags"); // carry and half kept
    #1 check({17'h0, alu_res}, 33'h0006, "alu result");
    u_core.alu(cdr_pkg::CDR_OP_OR, 1'b0);
    u_core.alu(4'hf, 1'b0);
    rd(8'h04, 16'h12ff, "or acc"); // low byte or
    rd(8'h18, 16'h0089, "bad op flags"); // no flag written
    for (i = 0; i < 7; i++)
    begin
      u_core.ld(3'd6, irq_tab[i][18:3]);
      u_core.sig(1'b1, irq_tab[i][2:1], 3'h0);
      @(posedge pclk);
      #1 check({32'h0, irq_ack}, {32'h0, irq_tab[i][0]}, "ack");
      u_core.sig(1'b0, ~irq_tab[i][2:1], 3'h0);
    end
    // second reset in mid-run brings back the start values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 16'hfffd, "iptr again"); // reset entry again
    rd(8'h04, 16'h0000, "acc again"); // cleared by reset
    rd(8'h18, 16'h0000, "psw again"); // enable cleared again
    stop_test();
  end
endmodule : cpu_dedicated_registers_ccr_tb_top

`default_nettype wire
